// >>> rtl/evdc_top.sv
/*
 * Event detect control: fast transition counter, slow switch debouncer,
 * watchdog clear routing, control register and interrupt logic.
 * Assumes a 100 MHz clk_i, a simple strobe register port and an oscillator,
 * fast input and slow input arriving as asynchronous pins.
 */
// The address map and strobed register access are this design's own decisions.
// Summary of operation
// - Event completion sets its flag; flag holds until software writes zero.
// - Fast detector runs only with its enable set and routing bit clear.
// - Slow debouncer runs only while its enable bit is set.
// - Routing bit set: each fast input edge pulses the watchdog clear.
// - Routing bit set disables fast detector, ignoring its enable.
// - Debounce length chosen by control bit 2.
// - Count select 00, 10, 11 needs 1, 16, 32 transitions.
// - Count select 01 needs 4 transitions.
// - Debounce lasts 1024 or 16384 oscillator cycles.
// - Transition count restarts if target not met within 8192 cycles.
// - Slow edge starts debounce; return aborts; expiry sets the flag.
`timescale 1ns/100ps

module evdc_top
    import evdc_pkg::*;
#(
    parameter int FAST_TIMEOUT = EVDC_FAST_TIMEOUT_CYC,
    parameter int DEB_SHORT = EVDC_DEB_SHORT_CYC,
    parameter int DEB_LONG = EVDC_DEB_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic osc_i,
    input wire logic fast_event_input_i,
    input wire logic slow_event_input_i,
    output logic wd_clear_o,
    output logic irq_o
);

    localparam int TW = $clog2(FAST_TIMEOUT);
    localparam int DW = $clog2(DEB_LONG);

    // ------------------------------------------------------------------
    // Input synchronisers and filtering
    // ------------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] lvl;
    logic osc_d;
    logic fast_d;
    logic osc_tick;
    logic fast_edge;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            lvl <= 3'h0;
            osc_d <= 1'b0;
            fast_d <= 1'b0;
        end else begin
            sync1 <= {slow_event_input_i, fast_event_input_i, osc_i};
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & lvl);
            osc_d <= lvl[0];
            fast_d <= lvl[1];
        end
    end

    assign osc_tick = lvl[0] & ~osc_d;
    assign fast_edge = lvl[1] ^ fast_d;

    // ------------------------------------------------------------------
    // Control register decode
    // ------------------------------------------------------------------
    logic [7:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic fast_active;
    logic slow_active;
    logic [5:0] target;
    logic [DW-1:0] deb_last;
    logic ctrl_wr;

    assign ctrl_wr = wr_i && (addr_i == EVDC_ADDR_CTRL);
    assign fast_active = ctrl[EVDC_FAST_EN_BIT] && !ctrl[EVDC_WD_CLR_EN_BIT];
    assign slow_active = ctrl[EVDC_SLOW_EN_BIT];
    assign deb_last = ctrl[EVDC_DEB_SEL_BIT] ? DW'(DEB_LONG - 1) : DW'(DEB_SHORT - 1);

    always_comb begin
        unique case (ctrl[EVDC_CNT_SEL_HI:EVDC_CNT_SEL_LO])
            2'b00: target = EVDC_TRANS_SEL0;
            2'b01: target = EVDC_TRANS_SEL1;
            2'b10: target = EVDC_TRANS_SEL2;
            2'b11: target = EVDC_TRANS_SEL3;
        endcase
    end

    // ------------------------------------------------------------------
    // Fast transition detector
    // ------------------------------------------------------------------
    logic [5:0] fcnt;
    logic [TW-1:0] ftmo;
    logic fprev;
    logic fast_step;
    logic fast_hit;

    assign fast_step = osc_tick && fast_active && (lvl[1] != fprev);
    assign fast_hit = fast_step && ((fcnt + 6'h01) == target);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fcnt <= 6'h00;
            ftmo <= '0;
            fprev <= 1'b0;
        end else begin
            if (osc_tick) begin
                fprev <= lvl[1];
            end
            if (!fast_active) begin
                fcnt <= 6'h00;
                ftmo <= '0;
            end else if (fast_hit) begin
                fcnt <= 6'h00;
                ftmo <= '0;
            end else if (fast_step && (ftmo == TW'(FAST_TIMEOUT - 1))) begin
                fcnt <= 6'h01;
                ftmo <= '0;
            end else if (fast_step) begin
                fcnt <= fcnt + 6'h01;
                ftmo <= (fcnt == 6'h00) ? '0 : ftmo + 1'b1;
            end else if (osc_tick && (fcnt != 6'h00)) begin
                if (ftmo == TW'(FAST_TIMEOUT - 1)) begin
                    fcnt <= 6'h00;
                    ftmo <= '0;
                end else begin
                    ftmo <= ftmo + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Slow debounce detector
    // ------------------------------------------------------------------
    logic deb_busy;
    logic deb_ref;
    logic [DW-1:0] deb_cnt;
    logic slow_hit;

    assign slow_hit = osc_tick && slow_active && deb_busy && (lvl[2] != deb_ref)
        && (deb_cnt == deb_last);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            deb_busy <= 1'b0;
            deb_ref <= 1'b0;
            deb_cnt <= '0;
        end else if (!slow_active) begin
            deb_busy <= 1'b0;
            deb_ref <= lvl[2];
            deb_cnt <= '0;
        end else if (osc_tick) begin
            if (!deb_busy) begin
                if (lvl[2] != deb_ref) begin
                    deb_busy <= 1'b1;
                    deb_cnt <= DW'(1);
                end
            end else if (lvl[2] == deb_ref) begin
                deb_busy <= 1'b0;
                deb_cnt <= '0;
            end else if (deb_cnt == deb_last) begin
                deb_busy <= 1'b0;
                deb_ref <= lvl[2];
                deb_cnt <= '0;
            end else begin
                deb_cnt <= deb_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register and watchdog clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= EVDC_CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl[5:0] <= wr_data_i[5:0];
            end
            ctrl[EVDC_FAST_FLAG_BIT] <= fast_hit ||
                (ctrl[EVDC_FAST_FLAG_BIT] && !(ctrl_wr && !wr_data_i[EVDC_FAST_FLAG_BIT]));
            ctrl[EVDC_SLOW_FLAG_BIT] <= slow_hit ||
                (ctrl[EVDC_SLOW_FLAG_BIT] && !(ctrl_wr && !wr_data_i[EVDC_SLOW_FLAG_BIT]));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_clear_o <= 1'b0;
        end else begin
            wd_clear_o <= ctrl[EVDC_WD_CLR_EN_BIT] && fast_edge;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, enable and output
    // ------------------------------------------------------------------
    logic [2:0] irq_set;

    assign irq_set = {wd_clear_o, slow_hit, fast_hit};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat <= EVDC_IRQ_RESET;
        end else if (wr_i && (addr_i == EVDC_ADDR_CLR)) begin
            irq_stat <= (irq_stat & ~wr_data_i[2:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en <= EVDC_IRQ_RESET;
        end else if (wr_i && (addr_i == EVDC_ADDR_IEN)) begin
            irq_en <= wr_data_i[2:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                EVDC_ADDR_CTRL: rd_data_o <= ctrl;
                EVDC_ADDR_STAT: rd_data_o <= {5'h00, irq_stat};
                EVDC_ADDR_IEN: rd_data_o <= {5'h00, irq_en};
                default: rd_data_o <= 8'h00;
            endcase
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    flag_hold_a: assert property (
        ctrl[EVDC_FAST_FLAG_BIT] && !(ctrl_wr && !wr_data_i[EVDC_FAST_FLAG_BIT])
        |=> ctrl[EVDC_FAST_FLAG_BIT])
        else $error("fast flag dropped without a zero write");

    fast_gate_a: assert property (
        !ctrl[EVDC_FAST_EN_BIT] |=> fcnt == 6'h00)
        else $error("fast counter moved while disabled");

    slow_gate_a: assert property (
        !ctrl[EVDC_SLOW_EN_BIT] |=> !deb_busy && !$rose(ctrl[EVDC_SLOW_FLAG_BIT]))
        else $error("debouncer active while disabled");

    wd_pulse_a: assert property (
        ctrl[EVDC_WD_CLR_EN_BIT] && fast_edge |=> wd_clear_o)
        else $error("fast edge did not clear watchdog");

    wd_blocks_a: assert property (
        ctrl[EVDC_WD_CLR_EN_BIT] |-> !fast_hit ##1 fcnt == 6'h00)
        else $error("fast detector ran while routed to watchdog");

    deb_select_a: assert property (
        slow_hit && !ctrl[EVDC_DEB_SEL_BIT] |-> deb_cnt == DW'(DEB_SHORT - 1))
        else $error("short debounce expired at wrong count");

    count_sel_a: assert property (
        fast_hit |-> fcnt == target - 6'h01 ##1 ctrl[EVDC_FAST_FLAG_BIT])
        else $error("fast event at wrong transition count");

    four_count_a: assert property (
        fast_hit && ctrl[1:0] == 2'b01 |-> fcnt == 6'h03)
        else $error("select 01 did not need four transitions");

    deb_expiry_a: assert property (
        osc_tick && slow_active && deb_busy && lvl[2] != deb_ref && deb_cnt == deb_last
        |=> ctrl[EVDC_SLOW_FLAG_BIT] && !deb_busy)
        else $error("debounce expiry did not set slow flag");

    timeout_a: assert property (
        osc_tick && fast_active && !fast_step && fcnt != 6'h00
        && ftmo == TW'(FAST_TIMEOUT - 1) |=> fcnt == 6'h00)
        else $error("transition count not reset on timeout");

    deb_abort_a: assert property (
        osc_tick && slow_active && deb_busy && lvl[2] == deb_ref
        |=> !deb_busy && !$rose(ctrl[EVDC_SLOW_FLAG_BIT]))
        else $error("debounce not aborted on return");

    osc_only_a: assert property (
        !osc_tick && fast_active |=> $stable(fcnt))
        else $error("transition counter moved without oscillator tick");

    deb_tick_a: assert property (
        !osc_tick && slow_active |=> $stable(deb_cnt))
        else $error("debounce counter moved without oscillator tick");

    irq_level_a: assert property (
        |(irq_stat & irq_en) |=> irq_o)
        else $error("enabled status did not raise interrupt");

    fast_event_c: cover property (fast_hit ##1 irq_stat[EVDC_IRQ_FAST_BIT]);
    slow_event_c: cover property (slow_hit);
    deb_abort_c: cover property (osc_tick && deb_busy && lvl[2] == deb_ref);
    wd_clear_c: cover property (wd_clear_o);

endmodule

// >>> pkg/evdc_pkg.sv
/*
 * Constants for the event detect control block: register offsets, control
 * field positions, reset values and oscillator cycle counts.
 * Assumes a single system clock and an oscillator that arrives on a pin.
 */
package evdc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] EVDC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] EVDC_ADDR_STAT = 4'h1;
    localparam logic [3:0] EVDC_ADDR_CLR = 4'h2;
    localparam logic [3:0] EVDC_ADDR_IEN = 4'h3;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int EVDC_FAST_FLAG_BIT = 7;
    localparam int EVDC_SLOW_FLAG_BIT = 6;
    localparam int EVDC_FAST_EN_BIT = 5;
    localparam int EVDC_SLOW_EN_BIT = 4;
    localparam int EVDC_WD_CLR_EN_BIT = 3;
    localparam int EVDC_DEB_SEL_BIT = 2;
    localparam int EVDC_CNT_SEL_HI = 1;
    localparam int EVDC_CNT_SEL_LO = 0;

    // ------------------------------------------------------------------
    // Interrupt status fields
    // ------------------------------------------------------------------
    localparam int EVDC_IRQ_FAST_BIT = 0;
    localparam int EVDC_IRQ_SLOW_BIT = 1;
    localparam int EVDC_IRQ_WD_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] EVDC_CTRL_RESET = 8'h00;
    localparam logic [2:0] EVDC_IRQ_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Oscillator cycle counts and transition counts
    // ------------------------------------------------------------------
    localparam int EVDC_FAST_TIMEOUT_CYC = 8192;
    localparam int EVDC_DEB_SHORT_CYC = 1024;
    localparam int EVDC_DEB_LONG_CYC = 16384;
    localparam logic [5:0] EVDC_TRANS_SEL0 = 6'h01;
    localparam logic [5:0] EVDC_TRANS_SEL1 = 6'h04;
    localparam logic [5:0] EVDC_TRANS_SEL2 = 6'h10;
    localparam logic [5:0] EVDC_TRANS_SEL3 = 6'h20;

endpackage

// >>> verif/evdc_src.sv
/*
 * Far side model: oscillator pin at one twentieth of clk_i (OSC_HALF 10), fast event source and switch.
 * Assumes the bench clock; every pin changes just after a clk_i edge.
 */
`timescale 1ns/100ps

module evdc_src #(
    parameter int OSC_HALF = 10
) (
    input wire logic clk_i,
    output logic osc_o,
    output logic fast_o,
    output logic slow_o
);
    logic osc_run;
    int osc_cnt;

    initial begin
        osc_o = 1'b0;
        fast_o = 1'b0;
        slow_o = 1'b0;
        osc_run = 1'b1;
        osc_cnt = 0;
    end

    // ------------------------------------------------------------------
    // Oscillator, held still while stopped
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (osc_run) begin
            osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
            if (osc_cnt == OSC_HALF - 1) begin
                osc_o <= ~osc_o;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin stimulus; each fast level held two ticks so every edge counts alone, slow level held the given ticks
    // ------------------------------------------------------------------
    task automatic ticks(input int n);
        repeat (n * 2 * OSC_HALF) @(posedge clk_i);
    endtask

    task automatic flip_fast(input int n);
        repeat (n) begin
            @(posedge clk_i);
            fast_o <= ~fast_o;
            ticks(2);
        end
    endtask

    task automatic flip_slow(input int hold);
        @(posedge clk_i);
        slow_o <= ~slow_o;
        ticks(hold);
    endtask
endmodule

// >>> verif/tb_top.sv
/*
 * Self-checking bench for the event detect control block.
 * Assumes shortened counts: timeout 128, debounce 4 and 8 ticks.
 */
`timescale 1ns/100ps

module tb_top
    import evdc_pkg::*;
;
    localparam int FT = 128;
    logic clk_i = 1'b0;
    logic rst_i;
    logic [3:0] addr_i;
    logic [7:0] wr_data_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rd_data_o;
    logic osc_i, fast_i, slow_i, wd_clear_o, irq_o;
    logic [7:0] wd_cnt;
    int err_count = 0;
    int n_checks = 0;

    always #5 clk_i = ~clk_i;

    evdc_top #(.FAST_TIMEOUT(FT), .DEB_SHORT(4), .DEB_LONG(8)) i_evdc_top (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .osc_i(osc_i),
        .fast_event_input_i(fast_i), .slow_event_input_i(slow_i),
        .wd_clear_o(wd_clear_o), .irq_o(irq_o));

    evdc_src i_evdc_src (.clk_i(clk_i), .osc_o(osc_i), .fast_o(fast_i), .slow_o(slow_i));

    always @(posedge clk_i) begin
        if (rst_i) begin
            wd_cnt <= 8'h00;
        end else if (wd_clear_o === 1'b1) begin
            wd_cnt <= wd_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk8(rd_data_o, exp, msg);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_values();
        rd_chk(EVDC_ADDR_CTRL, EVDC_CTRL_RESET, "ctrl reset");
        rd_chk(EVDC_ADDR_STAT, 8'h00, "status reset");
        rd_chk(EVDC_ADDR_IEN, 8'h00, "enable reset");
        chk8({7'h00, irq_o}, 8'h00, "irq reset");
    endtask

    task automatic fast_counts();
        int need[4] = '{1, 4, 16, 32};
        logic [7:0] c;
        for (int s = 0; s < 4; s++) begin
            c = 8'h20 | s[7:0];
            wr(EVDC_ADDR_CTRL, c);
            i_evdc_src.flip_fast(need[s] - 1);
            rd_chk(EVDC_ADDR_CTRL, c, "fast early");
            i_evdc_src.flip_fast(1);
            rd_chk(EVDC_ADDR_CTRL, c | 8'h80, "fast hit");
            wr(EVDC_ADDR_CTRL, 8'h00);
        end
    endtask

    task automatic fast_timeout();
        wr(EVDC_ADDR_CTRL, 8'h21);
        i_evdc_src.flip_fast(3);
        i_evdc_src.ticks(FT + 4);
        i_evdc_src.flip_fast(1);
        rd_chk(EVDC_ADDR_CTRL, 8'h21, "count restart");
        i_evdc_src.flip_fast(3);
        rd_chk(EVDC_ADDR_CTRL, 8'hA1, "hit after restart");
        wr(EVDC_ADDR_CTRL, 8'h00);
    endtask

    task automatic fast_off_and_wd();
        logic [7:0] w0;
        w0 = wd_cnt;
        i_evdc_src.flip_fast(2);
        rd_chk(EVDC_ADDR_CTRL, 8'h00, "fast disabled");
        chk8(wd_cnt, w0, "no wd clear");
        wr(EVDC_ADDR_CTRL, 8'h28);
        i_evdc_src.flip_fast(3);
        rd_chk(EVDC_ADDR_CTRL, 8'h28, "routed fast");
        chk8(wd_cnt, w0 + 8'h03, "wd clears");
        wr(EVDC_ADDR_CTRL, 8'h00);
    endtask

    task automatic slow_debounce();
        wr(EVDC_ADDR_CTRL, 8'h10);
        i_evdc_src.ticks(2);
        i_evdc_src.flip_slow(2);
        i_evdc_src.flip_slow(8);
        rd_chk(EVDC_ADDR_CTRL, 8'h10, "bounce aborted");
        i_evdc_src.flip_slow(8);
        rd_chk(EVDC_ADDR_CTRL, 8'h50, "short debounce");
        wr(EVDC_ADDR_CTRL, 8'h14);
        i_evdc_src.flip_slow(6);
        rd_chk(EVDC_ADDR_CTRL, 8'h14, "long not yet");
        i_evdc_src.ticks(4);
        rd_chk(EVDC_ADDR_CTRL, 8'h54, "long debounce");
        wr(EVDC_ADDR_CTRL, 8'h00);
        i_evdc_src.flip_slow(12);
        rd_chk(EVDC_ADDR_CTRL, 8'h00, "slow disabled");
    endtask

    task automatic flags_and_irq();
        rd_chk(EVDC_ADDR_STAT, 8'h07, "status all events");
        wr(EVDC_ADDR_IEN, 8'h01);
        wr(EVDC_ADDR_CLR, 8'h07);
        rd_chk(EVDC_ADDR_STAT, 8'h00, "status cleared");
        wr(EVDC_ADDR_CTRL, 8'h20);
        i_evdc_src.flip_fast(1);
        rd_chk(EVDC_ADDR_STAT, 8'h01, "status fast");
        chk8({7'h00, irq_o}, 8'h01, "irq raised");
        wr(EVDC_ADDR_CTRL, 8'hA0);
        rd_chk(EVDC_ADDR_CTRL, 8'hA0, "flag kept");
        wr(EVDC_ADDR_IEN, 8'h00);
        repeat (3) @(posedge clk_i);
        chk8({7'h00, irq_o}, 8'h00, "irq masked");
        wr(EVDC_ADDR_IEN, 8'h01);
        repeat (3) @(posedge clk_i);
        chk8({7'h00, irq_o}, 8'h01, "irq unmasked");
        wr(EVDC_ADDR_CLR, 8'h01);
        rd_chk(EVDC_ADDR_STAT, 8'h00, "status clear");
        chk8({7'h00, irq_o}, 8'h00, "irq cleared");
        wr(EVDC_ADDR_CTRL, 8'h00);
        rd_chk(EVDC_ADDR_CTRL, 8'h00, "flag cleared");
        rd_chk(EVDC_ADDR_CLR, 8'h00, "clear reads zero");
        wr(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00, "unmapped read");
        rd_chk(EVDC_ADDR_CTRL, 8'h00, "unmapped write");
    endtask

    task automatic osc_stopped();
        i_evdc_src.osc_run = 1'b0;
        wr(EVDC_ADDR_CTRL, 8'h20);
        i_evdc_src.flip_fast(1);
        rd_chk(EVDC_ADDR_CTRL, 8'h20, "no tick no event");
        i_evdc_src.osc_run = 1'b1;
        i_evdc_src.ticks(2);
        rd_chk(EVDC_ADDR_CTRL, 8'hA0, "event on restart");
        wr(EVDC_ADDR_CTRL, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Verdict, sequence and watchdog
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        addr_i = 4'h0;
        wr_data_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_values();
        fast_counts();
        fast_timeout();
        fast_off_and_wd();
        slow_debounce();
        flags_and_irq();
        osc_stopped();
        test_done();
    end

    initial begin
        #300_000;
        err_count++;
        test_done();
    end
endmodule
